// [srix_cfg.svh]
`ifndef SRIX_CFG_SVH
`define SRIX_CFG_SVH
// Opcodes
`define SRIX_OPC_POPD 8'h92
`define SRIX_OPC_POPU 8'h93
`define SRIX_OPC_PUSHD 8'h82
`define SRIX_OPC_PUSHU 8'h83
`define SRIX_OPC_PUSH_R 8'h70
`define SRIX_OPC_PUSH_IR 8'h71
`define SRIX_OPC_RET 8'hAF
`define SRIX_OPC_RCF 8'hCF
`define SRIX_OPC_RL_R 8'h90
`define SRIX_OPC_RL_IR 8'h91
`define SRIX_OPC_RLC_R 8'h10
`define SRIX_OPC_RLC_IR 8'h11
// Execution cycles
`define SRIX_CYC_USTK 4'h8
`define SRIX_CYC_PUSH 4'h8
`define SRIX_CYC_RET_INT 4'h8
`define SRIX_CYC_RET_EXT 4'hA
`define SRIX_CYC_ROT 4'h4
`define SRIX_CYC_RCF 4'h4
// Instruction lengths in bytes
`define SRIX_LEN_USTK 16'h0003
`define SRIX_LEN_TWO 16'h0002
`define SRIX_LEN_ONE 16'h0001
// Flag bit positions
`define SRIX_FLG_C 7
`define SRIX_FLG_Z 6
`define SRIX_FLG_S 5
`define SRIX_FLG_V 4
`define SRIX_FLG_D 3
`define SRIX_FLG_H 2
// Register byte offsets
`define SRIX_ADR_CTRL 8'h00
`define SRIX_ADR_INSTR 8'h04
`define SRIX_ADR_STATUS 8'h08
`define SRIX_ADR_PC 8'h0C
`define SRIX_ADR_SP 8'h10
`define SRIX_ADR_FLAGS 8'h14
`define SRIX_ADR_RF_IDX 8'h18
`define SRIX_ADR_RF_DATA 8'h1C
// Field positions
`define SRIX_CTRL_GO 0
`define SRIX_CTRL_EXT 1
`define SRIX_STS_BUSY 0
`define SRIX_STS_DONE 1
`define SRIX_STS_ILL 2
// Reset values and responses
`define SRIX_RST_PC 16'h0000
`define SRIX_RST_SP 16'h0000
`define SRIX_RST_FLAGS 8'h00
`define SRIX_RESP_OKAY 2'h0
`define SRIX_RESP_SLVERR 2'h2
`endif

// [srix_pkg.sv]
`default_nettype none
`include "srix_cfg.svh"
package srix_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_POPD, OP_POPU, OP_PUSHD, OP_PUSHU, OP_PUSH,
    OP_RET, OP_RCF, OP_RL, OP_RLC
  } srix_op_t;

  function automatic srix_op_t srix_decode(input logic [7:0] opc);
    unique case (opc)
      `SRIX_OPC_POPD: return OP_POPD;
      `SRIX_OPC_POPU: return OP_POPU;
      `SRIX_OPC_PUSHD: return OP_PUSHD;
      `SRIX_OPC_PUSHU: return OP_PUSHU;
      `SRIX_OPC_PUSH_R, `SRIX_OPC_PUSH_IR: return OP_PUSH;
      `SRIX_OPC_RET: return OP_RET;
      `SRIX_OPC_RCF: return OP_RCF;
      `SRIX_OPC_RL_R, `SRIX_OPC_RL_IR: return OP_RL;
      `SRIX_OPC_RLC_R, `SRIX_OPC_RLC_IR: return OP_RLC;
      default: return OP_NONE;
    endcase
  endfunction
endpackage
`default_nettype wire

// [srix_regfile.sv]
`timescale 1ns/10ps
`default_nettype none
// Data storage only, so no reset: software preloads what it needs
module srix_regfile (
  input wire logic clock,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  output logic [255:0][7:0] mem
);
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
endmodule // srix_regfile
`default_nettype wire

// [srix_rot.sv]
`timescale 1ns/10ps
`default_nettype none
`include "srix_cfg.svh"
module srix_rot (
  input wire logic [7:0] val,
  input wire logic thru,
  input wire logic [7:0] flags_in,
  output logic [7:0] res,
  output logic [7:0] flags_out
);
  always_comb begin
    res = {val[6:0], thru ? flags_in[`SRIX_FLG_C] : val[7]};
    flags_out = flags_in;
    flags_out[`SRIX_FLG_C] = val[7];
    flags_out[`SRIX_FLG_Z] = (res == 8'h00);
    flags_out[`SRIX_FLG_S] = res[7];
    // Sign change during the rotation counts as overflow
    flags_out[`SRIX_FLG_V] = val[7] ^ res[7];
  end
endmodule // srix_rot
`default_nettype wire

// [srix_core.sv]
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "srix_cfg.svh"
module srix_core import srix_pkg::*; (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busy,
  output logic [15:0] fetch_addr
);
  logic [7:0] aw_addr_q, rf_idx_q, b1_q, b2_q, data_q, flags_q;
  logic [3:0] w_strb_q;
  logic [31:0] w_data_q, instr_q;
  logic aw_have_q, w_have_q, ext_q, ind_q, done_q, ill_q;
  logic [15:0] pc_q, sp_q, len_q;
  logic [3:0] cnt_q, total_q;
  srix_op_t op_q, dec_op;
  logic [255:0][7:0] rf_mem;
  logic rf_we, wr_fire, go, step1, step2, mapped_w;
  logic [7:0] rf_wa, rf_wd, ptr, ind, srcb, rot_val, rot_addr, rot_res;
  logic [7:0] rot_flags;

  function automatic logic is_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= `SRIX_ADR_RF_DATA;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Register write, except the status write-one-to-clear, is only meaningful with the core stopped
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] t,
                                  input logic f, input logic b);
    return f && !b && a == t;
  endfunction

  // AXI4-Lite write address and data, taken in either order
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign mapped_w = is_mapped(aw_addr_q);

  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      aw_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_have_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      aw_have_q <= 1'b0;
    end else if (!aw_have_q) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_wready <= 1'b0;
      w_have_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_have_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      w_have_q <= 1'b0;
    end else if (!w_have_q) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SRIX_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped_w ? `SRIX_RESP_OKAY : `SRIX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read side: one outstanding read, answer one edge after the address
  always_ff @(posedge clock) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SRIX_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? `SRIX_RESP_OKAY
                                             : `SRIX_RESP_SLVERR;
      unique case (s_axi_araddr)
        `SRIX_ADR_CTRL: s_axi_rdata <= {30'h0, ext_q, 1'b0};
        `SRIX_ADR_INSTR: s_axi_rdata <= instr_q;
        `SRIX_ADR_STATUS: s_axi_rdata <= {29'h0, ill_q, done_q, busy};
        `SRIX_ADR_PC: s_axi_rdata <= {16'h0, pc_q};
        `SRIX_ADR_SP: s_axi_rdata <= {16'h0, sp_q};
        `SRIX_ADR_FLAGS: s_axi_rdata <= {24'h0, flags_q};
        `SRIX_ADR_RF_IDX: s_axi_rdata <= {24'h0, rf_idx_q};
        `SRIX_ADR_RF_DATA: s_axi_rdata <= {24'h0, rf_mem[rf_idx_q]};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Software-owned configuration
  always_ff @(posedge clock) begin
    if (srst) begin
      instr_q <= 32'h00000000;
      ext_q <= 1'b0;
      rf_idx_q <= 8'h00;
    end else begin
      if (wr_hit(aw_addr_q, `SRIX_ADR_INSTR, wr_fire, busy)) begin
        instr_q <= merge(instr_q, w_data_q, w_strb_q[3:0]);
      end
      if (wr_hit(aw_addr_q, `SRIX_ADR_CTRL, wr_fire, busy) && w_strb_q[0]) begin
        ext_q <= w_data_q[`SRIX_CTRL_EXT];
      end
      if (wr_hit(aw_addr_q, `SRIX_ADR_RF_IDX, wr_fire, busy) && w_strb_q[0]) begin
        rf_idx_q <= w_data_q[7:0];
      end
    end
  end

  assign go = wr_hit(aw_addr_q, `SRIX_ADR_CTRL, wr_fire, busy) &&
              w_strb_q[0] && w_data_q[`SRIX_CTRL_GO];
  assign dec_op = srix_decode(instr_q[7:0]);

  // Sequencer: first step two cycles before the end, second step last
  assign step1 = busy && cnt_q == total_q - 4'h2;
  assign step2 = busy && cnt_q == total_q - 4'h1;

  always_ff @(posedge clock) begin
    if (srst) begin
      busy <= 1'b0;
      cnt_q <= 4'h0;
      total_q <= 4'h0;
      len_q <= 16'h0000;
      op_q <= OP_NONE;
      ind_q <= 1'b0;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
    end else if (go && dec_op != OP_NONE) begin
      busy <= 1'b1;
      cnt_q <= 4'h0;
      op_q <= dec_op;
      ind_q <= instr_q[0];
      b1_q <= instr_q[15:8];
      b2_q <= instr_q[23:16];
      unique case (dec_op)
        OP_POPD, OP_POPU, OP_PUSHD, OP_PUSHU: begin
          total_q <= `SRIX_CYC_USTK;
          len_q <= `SRIX_LEN_USTK;
        end
        OP_PUSH: begin
          total_q <= `SRIX_CYC_PUSH;
          len_q <= `SRIX_LEN_TWO;
        end
        OP_RET: begin
          // Timing bit of this same go write, not the previous setting
          total_q <= w_data_q[`SRIX_CTRL_EXT] ? `SRIX_CYC_RET_EXT
                                               : `SRIX_CYC_RET_INT;
          len_q <= `SRIX_LEN_ONE;
        end
        OP_RCF: begin
          total_q <= `SRIX_CYC_RCF;
          len_q <= `SRIX_LEN_ONE;
        end
        default: begin
          total_q <= `SRIX_CYC_ROT;
          len_q <= `SRIX_LEN_TWO;
        end
      endcase
    end else if (step2) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // Status flags: hardware set beats a same-cycle write-one-to-clear
  always_ff @(posedge clock) begin
    if (srst) begin
      done_q <= 1'b0;
      ill_q <= 1'b0;
    end else begin
      if (step2) begin
        done_q <= 1'b1;
      end else if (wr_hit(aw_addr_q, `SRIX_ADR_STATUS, wr_fire, 1'b0) &&
                   w_data_q[`SRIX_STS_DONE]) begin
        done_q <= 1'b0;
      end
      if (go && dec_op == OP_NONE) begin
        ill_q <= 1'b1;
      end else if (wr_hit(aw_addr_q, `SRIX_ADR_STATUS, wr_fire, 1'b0) &&
                   w_data_q[`SRIX_STS_ILL]) begin
        ill_q <= 1'b0;
      end
    end
  end

  // Pointer and operands come straight from the register file
  assign ptr = rf_mem[b1_q];
  assign ind = rf_mem[ptr];
  assign srcb = rf_mem[b2_q];
  assign rot_val = ind_q ? ind : ptr;
  assign rot_addr = ind_q ? ptr : b1_q;

  srix_rot u_rot (
    .val(rot_val),
    .thru(op_q == OP_RLC),
    .flags_in(flags_q),
    .res(rot_res),
    .flags_out(rot_flags)
  );

  // Source latched early so a pointer-as-source sees its old value
  always_ff @(posedge clock) begin
    if (srst) begin
      data_q <= 8'h00;
    end else if (step1) begin
      data_q <= (op_q == OP_PUSH) ? rot_val : srcb;
    end
  end

  always_comb begin
    rf_we = 1'b0;
    rf_wa = 8'h00;
    rf_wd = 8'h00;
    if (step1 && (op_q == OP_POPD || op_q == OP_POPU)) begin
      rf_we = 1'b1;
      rf_wa = b2_q;
      rf_wd = ind;
    end else if (step1 && (op_q == OP_PUSHD || op_q == OP_PUSHU)) begin
      rf_we = 1'b1;
      rf_wa = b1_q;
      rf_wd = (op_q == OP_PUSHD) ? ptr - 8'h01 : ptr + 8'h01;
    end else if (step2 && (op_q == OP_POPD || op_q == OP_POPU)) begin
      rf_we = 1'b1;
      rf_wa = b1_q;
      rf_wd = (op_q == OP_POPD) ? ptr - 8'h01 : ptr + 8'h01;
    end else if (step2 && (op_q == OP_PUSHD || op_q == OP_PUSHU)) begin
      rf_we = 1'b1;
      rf_wa = ptr;
      rf_wd = data_q;
    end else if (step2 && op_q == OP_PUSH) begin
      rf_we = 1'b1;
      rf_wa = sp_q[7:0];
      rf_wd = data_q;
    end else if (step2 && (op_q == OP_RL || op_q == OP_RLC)) begin
      rf_we = 1'b1;
      rf_wa = rot_addr;
      rf_wd = rot_res;
    end else if (wr_hit(aw_addr_q, `SRIX_ADR_RF_DATA, wr_fire, busy) &&
                 w_strb_q[0]) begin
      rf_we = 1'b1;
      rf_wa = rf_idx_q;
      rf_wd = w_data_q[7:0];
    end
  end

  srix_regfile u_rf (
    .clock(clock),
    .we(rf_we),
    .waddr(rf_wa),
    .wdata(rf_wd),
    .mem(rf_mem)
  );

  always_ff @(posedge clock) begin
    if (srst) begin
      sp_q <= `SRIX_RST_SP;
    end else if (step1 && op_q == OP_PUSH) begin
      sp_q <= sp_q - 16'h0001;
    end else if (step2 && op_q == OP_RET) begin
      sp_q <= sp_q + 16'h0002;
    end else if (wr_hit(aw_addr_q, `SRIX_ADR_SP, wr_fire, busy)) begin
      sp_q <= 16'(merge({16'h0, sp_q}, w_data_q, w_strb_q[3:0]));
    end
  end

  // Internal stack: only the low pointer byte indexes the register file
  always_ff @(posedge clock) begin
    if (srst) begin
      pc_q <= `SRIX_RST_PC;
    end else if (step2 && op_q == OP_RET) begin
      pc_q <= {rf_mem[sp_q[7:0]], rf_mem[sp_q[7:0] + 8'h01]};
    end else if (step2) begin
      pc_q <= pc_q + len_q;
    end else if (wr_hit(aw_addr_q, `SRIX_ADR_PC, wr_fire, busy)) begin
      pc_q <= 16'(merge({16'h0, pc_q}, w_data_q, w_strb_q[3:0]));
    end
  end
  assign fetch_addr = pc_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      flags_q <= `SRIX_RST_FLAGS;
    end else if (step2 && op_q == OP_RCF) begin
      flags_q[`SRIX_FLG_C] <= 1'b0;
    end else if (step2 && (op_q == OP_RL || op_q == OP_RLC)) begin
      flags_q <= rot_flags;
    end else if (wr_hit(aw_addr_q, `SRIX_ADR_FLAGS, wr_fire, busy) &&
                 w_strb_q[0]) begin
      flags_q <= w_data_q[7:0];
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_start(srix_op_t k);
    $rose(busy) && op_q == k;
  endsequence
  sequence s_run8;
    busy [*8] ##1 !busy;
  endsequence
  property p_pop_time;
    s_start(OP_POPD) |-> s_run8;
  endproperty
  a_pop_time: assert property (p_pop_time) else $error("pop time");
  property p_popu;
    step2 && op_q == OP_POPU |=> rf_mem[b1_q] == $past(ptr) + 8'h01;
  endproperty
  a_popu: assert property (p_popu) else $error("popu ptr");
  property p_push_sp;
    s_start(OP_PUSH) |-> ##7 (sp_q == $past(sp_q, 7) - 16'h0001)
      ##1 rf_mem[sp_q[7:0]] == data_q;
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push order");
  property p_pushd;
    step2 && op_q == OP_PUSHD |=> rf_mem[$past(ptr)] == $past(data_q);
  endproperty
  a_pushd: assert property (p_pushd) else $error("pushd data");
  property p_noflag;
    busy && op_q inside {OP_POPD, OP_POPU, OP_PUSHD, OP_PUSHU, OP_PUSH,
                         OP_RET} |=> $stable(flags_q);
  endproperty
  a_noflag: assert property (p_noflag) else $error("flags moved");
  property p_rcf;
    step2 && op_q == OP_RCF |=> !flags_q[`SRIX_FLG_C] &&
      flags_q[6:0] == $past(flags_q[6:0]);
  endproperty
  a_rcf: assert property (p_rcf) else $error("rcf");
  property p_ret;
    step2 && op_q == OP_RET |=> sp_q == $past(sp_q) + 16'h0002 &&
      pc_q[15:8] == $past(rf_mem[sp_q[7:0]]);
  endproperty
  a_ret: assert property (p_ret) else $error("ret");
  property p_rl;
    step2 && op_q == OP_RL |=> flags_q[`SRIX_FLG_C] == $past(rot_val[7]) &&
      rf_mem[$past(rot_addr)][0] == $past(rot_val[7]) &&
      flags_q[`SRIX_FLG_V] == ($past(rot_val[7]) ^ $past(rot_val[6]));
  endproperty
  a_rl: assert property (p_rl) else $error("rotate");
endmodule // srix_core
`default_nettype wire

// [srix_host.sv]
`timescale 1ns/10ps
`default_nettype none
// Software side of the register bus: one write and one read at a time
module srix_host (
  input wire logic clock,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Each channel dropped only at the edge that takes it
  task automatic write(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge clock); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule // srix_host
`default_nettype wire

// [testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "srix_cfg.svh"
module testbench;
  logic clock, srst, busy, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, f;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] fetch_addr, epc;
  logic [55:0] r;
  int mismatches, n_tests, bc, blen;
  // op, operand byte, target, value, flags in, result, flags out
  logic [55:0] rot [7] = '{56'h90_30_30_AA_0C_55_9C,
    56'h90_30_30_00_0C_00_4C, 56'h90_30_30_40_0C_80_3C,
    56'h91_01_02_17_FC_2E_0C, 56'h10_30_30_AA_0C_54_9C,
    56'h10_30_30_2A_8C_55_0C, 56'h11_01_02_17_0C_2E_0C};

  srix_core uut (.clock(clock), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .busy(busy),
    .fetch_addr(fetch_addr));

  srix_host host (.clock(clock), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Length of the last busy pulse, in clocks
  always @(posedge clock) begin
    if (busy === 1'b1) bc <= bc + 1;
    else if (bc != 0) begin
      blen <= bc;
      bc <= 0;
    end
  end

  task automatic final_report;
    $display("Checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.write(a, d, resp);
  endtask

  task automatic regc(input string nm, input logic [7:0] a,
      input logic [31:0] e, input logic [31:0] m);
    host.read(a, rdat, resp);
    chk(nm, e, rdat & m);
  endtask

  task automatic rfw(input logic [7:0] i, input logic [7:0] v);
    wr(`SRIX_ADR_RF_IDX, {24'h0, i});
    wr(`SRIX_ADR_RF_DATA, {24'h0, v});
  endtask

  task automatic rfc(input logic [7:0] i, input logic [7:0] e);
    wr(`SRIX_ADR_RF_IDX, {24'h0, i});
    regc($sformatf("rf %h", i), `SRIX_ADR_RF_DATA, {24'h0, e}, 32'hFF);
  endtask

  function automatic logic [31:0] ins(input logic [7:0] op, b1, b2);
    return {8'h00, b2, b1, op};
  endfunction

  // Busy already high when the go write completes
  task automatic exec(input logic [31:0] i, input logic [1:0] c,
      input int n, input logic [15:0] npc);
    int k;
    wr(`SRIX_ADR_INSTR, i);
    wr(`SRIX_ADR_CTRL, {30'h0, c});
    k = 0;
    while (busy !== 1'b0 && k < 40) begin
      @(posedge clock);
      k++;
    end
    repeat (2) @(posedge clock);
    chk("busy cycles", n, blen);
    chk("fetch address", {16'h0, npc}, {16'h0, fetch_addr});
    epc = npc;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    final_report;
  end

  initial begin
    srst = 1'b1;
    epc = 16'h0000;
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    chk("fetch address", 32'h0, {16'h0, fetch_addr});
    regc("program counter", `SRIX_ADR_PC, 32'h0, 32'hFFFF);
    regc("stack pointer", `SRIX_ADR_SP, 32'h0, 32'hFFFF);
    regc("flags", `SRIX_ADR_FLAGS, 32'h0, 32'hFF);
    regc("unmapped data", 8'h20, 32'h0, 32'hFFFFFFFF);
    chk("unmapped read", {30'h0, `SRIX_RESP_SLVERR}, {30'h0, resp});
    wr(8'h06, 32'h1);
    chk("unaligned write", {30'h0, `SRIX_RESP_SLVERR}, {30'h0, resp});
    wr(`SRIX_ADR_FLAGS, 32'hFC);
    rfw(8'h00, 8'h42);
    rfw(8'h42, 8'h6F);
    rfw(8'h02, 8'h70);
    exec(ins(8'h92, 8'h00, 8'h02), 2'h1, 8, epc + 16'h3);
    rfc(8'h02, 8'h6F);
    rfc(8'h00, 8'h41);
    rfw(8'h00, 8'hFF);
    rfw(8'hFF, 8'h70);
    exec(ins(8'h93, 8'h00, 8'h02), 2'h1, 8, epc + 16'h3);
    rfc(8'h02, 8'h70);
    rfc(8'h00, 8'h00);
    rfw(8'h10, 8'h00);
    rfw(8'h11, 8'h05);
    exec(ins(8'h82, 8'h10, 8'h11), 2'h1, 8, epc + 16'h3);
    rfc(8'h10, 8'hFF);
    rfc(8'hFF, 8'h05);
    rfw(8'h10, 8'h03);
    exec(ins(8'h83, 8'h10, 8'h11), 2'h1, 8, epc + 16'h3);
    rfc(8'h10, 8'h04);
    rfc(8'h04, 8'h05);
    wr(`SRIX_ADR_SP, 32'h0);
    rfw(8'h40, 8'h4F);
    rfw(8'h4F, 8'hAA);
    exec(ins(8'h70, 8'h40, 8'h00), 2'h1, 8, epc + 16'h2);
    regc("stack pointer", `SRIX_ADR_SP, 32'hFFFF, 32'hFFFF);
    rfc(8'hFF, 8'h4F);
    exec(ins(8'h71, 8'h40, 8'h00), 2'h1, 8, epc + 16'h2);
    regc("stack pointer", `SRIX_ADR_SP, 32'hFFFE, 32'hFFFF);
    rfc(8'hFE, 8'hAA);
    regc("flags", `SRIX_ADR_FLAGS, 32'hFC, 32'hFF);
    wr(`SRIX_ADR_SP, 32'h00FC);
    rfw(8'hFC, 8'h10);
    rfw(8'hFD, 8'h1A);
    exec(ins(8'hAF, 8'h0, 8'h0), 2'h1, 8, 16'h101A);
    regc("stack pointer", `SRIX_ADR_SP, 32'h00FE, 32'hFFFF);
    regc("program counter", `SRIX_ADR_PC, 32'h101A, 32'hFFFF);
    rfw(8'hFE, 8'h20);
    rfw(8'hFF, 8'h30);
    exec(ins(8'hAF, 8'h0, 8'h0), 2'h3, 10, 16'h2030);
    regc("stack pointer", `SRIX_ADR_SP, 32'h0100, 32'hFFFF);
    regc("flags", `SRIX_ADR_FLAGS, 32'hFC, 32'hFF);
    for (int j = 0; j < 2; j++) begin
      f = j ? 8'h7C : 8'hFC;
      wr(`SRIX_ADR_FLAGS, {24'h0, f});
      exec(ins(8'hCF, 8'h0, 8'h0), 2'h1, 4, epc + 16'h1);
      regc("flags", `SRIX_ADR_FLAGS, {24'h0, f & 8'h7F}, 32'hFF);
    end
    rfw(8'h01, 8'h02);
    for (int j = 0; j < 7; j++) begin
      r = rot[j];
      rfw(r[39:32], r[31:24]);
      wr(`SRIX_ADR_FLAGS, {24'h0, r[23:16]});
      exec(ins(r[55:48], r[47:40], 8'h0), 2'h1, 4, epc + 16'h2);
      rfc(r[39:32], r[15:8]);
      regc("flags", `SRIX_ADR_FLAGS, {24'h0, r[7:0]}, 32'hFF);
    end
    wr(`SRIX_ADR_INSTR, 32'hFF);
    wr(`SRIX_ADR_CTRL, 32'h1);
    chk("busy", 32'h0, {31'h0, busy});
    regc("status", `SRIX_ADR_STATUS, 32'h6, 32'h7);
    wr(`SRIX_ADR_STATUS, 32'h6);
    regc("status", `SRIX_ADR_STATUS, 32'h0, 32'h7);
    chk("fetch address", {16'h0, epc}, {16'h0, fetch_addr});
    final_report;
  end
endmodule // testbench
`default_nettype wire
